/* File: rtl/ptb_time_base.sv */
// PWM time base: 15-bit up or up/down counter with AXI4-Lite registers.
//
// Functional notes
// - 15-bit counter, prescaled input, postscaled event output.
// - Count bit 15 reads direction, read-only.
// - Counter runs only while enable bit set.
// - Clearing enable keeps the count value.
// - Match resets or reverses on next tick.
// - Zero period stops counting and all events.
// - Zero active period blocks reload until disabled.
// - Two-bit mode selects one of four modes.
// - Events follow mode and four-bit postscaler.
// - Free running counts up, wraps after match.
// - Free running: postscaled event per wrap.
// - Single shot wraps once, hardware clears enable.
// - Single shot: one event, postscaler ignored.
// - Up/down: postscaled event at zero turnaround.
// - Double update: events at zero and match.
// - Prescaler divides by 1, 4, 16 or 64.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module ptb_time_base (
  input wire logic aclk, // Instruction clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [5:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [5:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [14:0] count_out, // Present count.
  output logic count_down_flag, // High while counting down.
  output logic match_pulse, // Count met the period.
  output logic zero_pulse, // Count reached zero.
  output logic event_pulse, // Postscaled time-base event.
  output logic irq // Level interrupt.
);
  // Bus slave state.
  logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
  logic [5:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  // Time-base state.
  logic time_base_on_ff, count_down_flag_ff, irq_ff;
  logic match_ff, zero_ff, event_ff;
  logic [1:0] time_base_mode_sel_ff, prescale_sel_ff;
  logic [3:0] postscale_sel_ff, post_cnt_ff;
  logic [14:0] time_base_count_ff, period_buf_ff, period_act_ff;
  logic [2:0] status_ff, irq_en_ff;
  // Combinational helpers.
  logic wr_fire, wr_ok, wr_ctl, wr_cnt, wr_per;
  logic [31:0] ctl_word, ctl_new, cnt_new, per_new, en_new;
  logic pre_clear, tick, run, at_match, reload, hw_stop;
  logic nxt_match, nxt_zero, post_cand, raw_cand, nxt_event, nxt_dir;
  logic [14:0] nxt_count;
  logic [2:0] ev_set;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic mapped(input logic [5:0] a);
    mapped = (a == ptb_pkg::OFS_CONTROL) || (a == ptb_pkg::OFS_COUNT) ||
             (a == ptb_pkg::OFS_PERIOD) || (a == ptb_pkg::OFS_STATUS) ||
             (a == ptb_pkg::OFS_CLEAR) || (a == ptb_pkg::OFS_ENABLE) ||
             (a == ptb_pkg::OFS_ACTIVE);
  endfunction

  // Write path: address and data are caught independently.
  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_ok = mapped(aw_addr_ff);
  assign wr_ctl = wr_fire && (aw_addr_ff == ptb_pkg::OFS_CONTROL);
  assign wr_cnt = wr_fire && (aw_addr_ff == ptb_pkg::OFS_COUNT);
  assign wr_per = wr_fire && (aw_addr_ff == ptb_pkg::OFS_PERIOD);

  assign ctl_word = {23'h000000, prescale_sel_ff, postscale_sel_ff,
                     time_base_mode_sel_ff, time_base_on_ff};
  assign ctl_new = merge(ctl_word, w_data_ff, w_strb_ff);
  assign cnt_new = merge({17'h00000, time_base_count_ff}, w_data_ff,
                         w_strb_ff);
  assign per_new = merge({17'h00000, period_buf_ff}, w_data_ff, w_strb_ff);
  assign en_new = merge({29'h00000000, irq_en_ff}, w_data_ff, w_strb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      aw_addr_ff <= 6'h00;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ptb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? ptb_pkg::RESP_OKAY : ptb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read path: one read at a time, data from a register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      rresp_ff <= ptb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      rresp_ff <= mapped(s_axi_araddr) ? ptb_pkg::RESP_OKAY
                                       : ptb_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        ptb_pkg::OFS_CONTROL: rdata_ff <= ctl_word;
        ptb_pkg::OFS_COUNT: begin
          rdata_ff <= {16'h0000, count_down_flag_ff,
                       time_base_count_ff};
        end
        ptb_pkg::OFS_PERIOD: rdata_ff <= {17'h00000, period_buf_ff};
        ptb_pkg::OFS_STATUS: rdata_ff <= {29'h00000000, status_ff};
        ptb_pkg::OFS_ENABLE: rdata_ff <= {29'h00000000, irq_en_ff};
        ptb_pkg::OFS_ACTIVE: rdata_ff <= {17'h00000, period_act_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Writes to count or control restart both scalers.
  assign pre_clear = wr_ctl || wr_cnt;

  ptb_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(pre_clear),
    .sel(prescale_sel_ff),
    .tick(tick)
  );

  // A zero active period freezes the counter and its events.
  assign run = time_base_on_ff && tick &&
               (period_act_ff != 15'h0000);
  assign at_match = (time_base_count_ff == period_act_ff);

  always_comb begin
    nxt_count = time_base_count_ff;
    nxt_dir = count_down_flag_ff;
    nxt_match = 1'b0;
    nxt_zero = 1'b0;
    post_cand = 1'b0;
    raw_cand = 1'b0;
    reload = 1'b0;
    hw_stop = 1'b0;
    if (run) begin
      unique case (time_base_mode_sel_ff)
        ptb_pkg::MODE_FREE, ptb_pkg::MODE_SINGLE: begin
          if (at_match) begin
            nxt_count = 15'h0000;
            nxt_match = 1'b1;
            nxt_zero = 1'b1;
            reload = 1'b1;
            if (time_base_mode_sel_ff == ptb_pkg::MODE_SINGLE) begin
              hw_stop = 1'b1;
              raw_cand = 1'b1;
            end else begin
              post_cand = 1'b1;
            end
          end else begin
            nxt_count = time_base_count_ff + 15'h0001;
          end
        end
        ptb_pkg::MODE_UPDN, ptb_pkg::MODE_DOUBLE: begin
          if (!count_down_flag_ff) begin
            if (at_match) begin
              nxt_dir = 1'b1;
              nxt_count = time_base_count_ff - 15'h0001;
              nxt_match = 1'b1;
              raw_cand = (time_base_mode_sel_ff ==
                          ptb_pkg::MODE_DOUBLE);
            end else begin
              nxt_count = time_base_count_ff + 15'h0001;
            end
          end else begin
            nxt_count = time_base_count_ff - 15'h0001;
            if (time_base_count_ff <= 15'h0001) begin
              nxt_count = 15'h0000;
              nxt_dir = 1'b0;
              nxt_zero = 1'b1;
              reload = 1'b1;
              if (time_base_mode_sel_ff == ptb_pkg::MODE_UPDN) begin
                post_cand = 1'b1;
              end else begin
                raw_cand = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // Postscaler passes one of every postscale_sel+1 candidates.
  assign nxt_event = raw_cand ||
                     (post_cand && (post_cnt_ff >= postscale_sel_ff));

  always_ff @(posedge aclk) begin
    if (!aresetn || pre_clear) begin
      post_cnt_ff <= 4'h0;
    end else if (post_cand) begin
      if (post_cnt_ff >= postscale_sel_ff) begin
        post_cnt_ff <= 4'h0;
      end else begin
        post_cnt_ff <= post_cnt_ff + 4'h1;
      end
    end
  end

  // Control register; a software write overrides the hardware stop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_on_ff <= 1'b0;
      time_base_mode_sel_ff <= ptb_pkg::MODE_FREE;
      postscale_sel_ff <= 4'h0;
      prescale_sel_ff <= 2'h0;
    end else if (wr_ctl) begin
      time_base_on_ff <= ctl_new[ptb_pkg::CTL_ON];
      time_base_mode_sel_ff <= ctl_new[ptb_pkg::CTL_MODE_LO +: 2];
      postscale_sel_ff <= ctl_new[ptb_pkg::CTL_POST_LO +: 4];
      prescale_sel_ff <= ctl_new[ptb_pkg::CTL_PRE_LO +: 2];
    end else if (hw_stop) begin
      time_base_on_ff <= 1'b0;
    end
  end

  // Counter and direction; disabling leaves both as they are.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_count_ff <= ptb_pkg::COUNT_RESET;
      count_down_flag_ff <= 1'b0;
    end else if (wr_cnt) begin
      time_base_count_ff <= cnt_new[ptb_pkg::CNT_W-1:0];
    end else begin
      time_base_count_ff <= nxt_count;
      count_down_flag_ff <= nxt_dir;
    end
  end

  // Period buffer and the active copy used for compares.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_buf_ff <= ptb_pkg::PERIOD_RESET;
    end else if (wr_per) begin
      period_buf_ff <= per_new[ptb_pkg::CNT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_act_ff <= ptb_pkg::PERIOD_RESET;
    end else if (!time_base_on_ff || reload) begin
      period_act_ff <= period_buf_ff;
    end
  end

  // Event pulses toward the rest of the PWM unit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_ff <= 1'b0;
      zero_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      match_ff <= nxt_match;
      zero_ff <= nxt_zero;
      event_ff <= nxt_event;
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  assign ev_set = {nxt_zero, nxt_match, nxt_event};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 3'h0;
    end else if (wr_fire && aw_addr_ff == ptb_pkg::OFS_CLEAR &&
                 w_strb_ff[0]) begin
      status_ff <= (status_ff & ~w_data_ff[ptb_pkg::EV_W-1:0]) | ev_set;
    end else begin
      status_ff <= status_ff | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff <= 3'h0;
    end else if (wr_fire && aw_addr_ff == ptb_pkg::OFS_ENABLE) begin
      irq_en_ff <= en_new[ptb_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & irq_en_ff);
    end
  end

  assign count_out = time_base_count_ff;
  assign count_down_flag = count_down_flag_ff;
  assign match_pulse = match_ff;
  assign zero_pulse = zero_ff;
  assign event_pulse = event_ff;
  assign irq = irq_ff;
endmodule

/* File: rtl/ptb_pkg.sv */
// Package with register map, field layout and encodings of the PWM time base.
package ptb_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_COUNT = 6'h04;
  localparam logic [5:0] OFS_PERIOD = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0c;
  localparam logic [5:0] OFS_CLEAR = 6'h10;
  localparam logic [5:0] OFS_ENABLE = 6'h14;
  localparam logic [5:0] OFS_ACTIVE = 6'h18;
  localparam int CTL_ON = 0;
  localparam int CTL_MODE_LO = 1;
  localparam int CTL_POST_LO = 3;
  localparam int CTL_PRE_LO = 7;
  localparam int CNT_DIR = 15;
  localparam int CNT_W = 15;
  localparam int EV_W = 3;
  localparam int EV_TB = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_ZERO = 2;
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;
  localparam logic [5:0] PRE_LIM_1 = 6'h00;
  localparam logic [5:0] PRE_LIM_4 = 6'h03;
  localparam logic [5:0] PRE_LIM_16 = 6'h0f;
  localparam logic [5:0] PRE_LIM_64 = 6'h3f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [14:0] PERIOD_RESET = 15'h0000;
  localparam logic [14:0] COUNT_RESET = 15'h0000;
endpackage

/* File: rtl/ptb_prescaler.sv */
// Prescaler that turns the instruction clock into count ticks.
`timescale 1ns/100ps
module ptb_prescaler (
  input wire logic aclk, // Instruction clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic clear, // Restarts the division.
  input wire logic [1:0] sel, // Ratio 1:1, 1:4, 1:16 or 1:64.
  output logic tick // One-cycle count tick.
);
  logic [5:0] div_ff;
  logic [5:0] limit;

  function automatic logic [5:0] pre_limit(input logic [1:0] s);
    unique case (s)
      2'h0: pre_limit = ptb_pkg::PRE_LIM_1;
      2'h1: pre_limit = ptb_pkg::PRE_LIM_4;
      2'h2: pre_limit = ptb_pkg::PRE_LIM_16;
      2'h3: pre_limit = ptb_pkg::PRE_LIM_64;
    endcase
  endfunction

  assign limit = pre_limit(sel);
  assign tick = !clear && (div_ff >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || tick) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end
endmodule

/* File: bench/ptb_asserts.sv */
// Concurrent checks on the ports of the PWM time base.
`timescale 1ns/100ps
module ptb_asserts (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic [1:0] s_axi_rresp, // R response.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic [14:0] count_out, // Count.
  input wire logic count_down_flag, // Direction.
  input wire logic match_pulse, // Match.
  input wire logic zero_pulse // Zero.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid dropped early");
  AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  AST_AR_RDY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  AST_ERR_ZERO: assert property (s_axi_rvalid
    && s_axi_rresp == ptb_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  AST_MATCH_TURN: assert property (
    match_pulse |-> count_out == 15'h0 || count_down_flag)
    else $error("match without wrap or reversal");
  AST_ZERO_UP: assert property (
    zero_pulse |-> count_out == 15'h0 && !count_down_flag)
    else $error("zero event with bad count or direction");
  AST_DIR_DOWN: assert property (
    $past(aresetn) && $rose(count_down_flag) |-> match_pulse)
    else $error("direction turned down without match");
  AST_DIR_UP: assert property (
    $past(aresetn) && $fell(count_down_flag) |-> zero_pulse)
    else $error("direction turned up away from zero");
endmodule

bind ptb_time_base ptb_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_out,
  .count_down_flag, .match_pulse, .zero_pulse);

/* File: bench/ptb_time_base_bench.sv */
// Self-checking testbench of the PWM time base.
`timescale 1ns/100ps
module ptb_time_base_bench;
  logic aclk, aresetn;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, count_down_flag, irq;
  logic [14:0] count_out;
  logic match_pulse, zero_pulse, event_pulse;
  logic [31:0] w;
  int fails = 0;
  int check_count = 0;
  int ne = 0;
  int c;
  ptb_time_base uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_out,
    .count_down_flag, .match_pulse, .zero_pulse, .event_pulse, .irq);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (event_pulse === 1'b1) ne <= ne + 1;
  end
  task automatic print_verdict;
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Offsets past the last mapped register answer with an error.
  function automatic logic [1:0] er(input logic [5:0] a);
    return a > ptb_pkg::OFS_ACTIVE ? ptb_pkg::RESP_SLVERR
      : ptb_pkg::RESP_OKAY;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, er(a));
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rvalid, 1'b1);
    chk(s_axi_rresp, er(a));
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
  endtask
  function automatic logic hit(input int s);
    return s == 0 ? zero_pulse : s == 1 ? event_pulse : match_pulse;
  endfunction
  // Counts the cycles between two successive pulses of one kind.
  task automatic gap(input int s, output int n);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (hit(s) !== 1'b1 && n < 3000);
    end
  endtask
  task automatic setup(input logic [31:0] ctl);
    do_reset;
    wr(ptb_pkg::OFS_PERIOD, 32'h3);
    wr(ptb_pkg::OFS_CONTROL, ctl);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rdc(6'(4 * i), 32'h0);
    rdc(6'h3c, 32'h0);
    wr(6'h3c, 32'h1);
    wr(ptb_pkg::OFS_PERIOD, 32'hffff);
    rdc(ptb_pkg::OFS_PERIOD, 32'h7fff);
  endtask
  task automatic t_count;
    for (int s = 3; s >= 0; s--) begin
      setup(32'h1 | (s << 7));
      gap(0, c);
      chk(c, 4 << (2 * s));
    end
    for (int i = 1; i < 5; i++) begin
      @(posedge aclk);
      chk(count_out, i % 4);
    end
  endtask
  task automatic t_post;
    for (int s = 0; s < 4; s++) begin
      setup(32'h1 | (s << 3));
      gap(1, c);
      chk(c, 4 * (s + 1));
    end
  endtask
  task automatic t_irq;
    wr(ptb_pkg::OFS_ENABLE, 32'h1);
    cyc(2);
    chk(irq, 1);
    wr(ptb_pkg::OFS_PERIOD, 32'h7fff);
    cyc(8);
    wr(ptb_pkg::OFS_CONTROL, 32'h0);
    rd(ptb_pkg::OFS_COUNT, w);
    chk(w[14:0] == 15'h0, 0);
    cyc(20);
    rdc(ptb_pkg::OFS_COUNT, w);
    chk(count_out, w[14:0]);
    rdc(ptb_pkg::OFS_STATUS, 32'h7);
    wr(ptb_pkg::OFS_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 0);
    wr(ptb_pkg::OFS_ENABLE, 32'h1);
    wr(ptb_pkg::OFS_CLEAR, 32'h7);
    cyc(2);
    chk(irq, 0);
    rdc(ptb_pkg::OFS_STATUS, 32'h0);
    wr(ptb_pkg::OFS_COUNT, 32'h8005);
    rdc(ptb_pkg::OFS_COUNT, 32'h5);
  endtask
  task automatic t_single;
    setup(32'h1b);
    w = ne;
    cyc(40);
    chk(ne - w, 1);
    rdc(ptb_pkg::OFS_CONTROL, 32'h1a);
    chk(count_out, 0);
  endtask
  task automatic t_updown;
    setup(32'h5);
    gap(2, c);
    chk(c, 6);
    chk({count_down_flag, count_out}, 16'h8002);
    gap(0, c);
    chk(c, 6);
    chk({count_down_flag, count_out}, 16'h0);
    w = ne;
    cyc(60);
    chk(ne - w, 10);
  endtask
  task automatic t_double;
    setup(32'h1f);
    gap(0, c);
    w = ne;
    cyc(60);
    chk(ne - w, 20);
  endtask
  task automatic t_zero;
    do_reset;
    wr(ptb_pkg::OFS_ENABLE, 32'h7);
    wr(ptb_pkg::OFS_CONTROL, 32'h1);
    w = ne;
    cyc(50);
    chk(ne - w, 0);
    chk(count_out, 0);
    chk(irq, 0);
    wr(ptb_pkg::OFS_PERIOD, 32'h5);
    rdc(ptb_pkg::OFS_ACTIVE, 32'h0);
    wr(ptb_pkg::OFS_CONTROL, 32'h0);
    rdc(ptb_pkg::OFS_ACTIVE, 32'h5);
  endtask
  initial begin
    cyc(20000);
    fails++;
    print_verdict;
  end
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    t_reset;
    t_count;
    t_post;
    t_irq;
    t_single;
    t_updown;
    t_double;
    t_zero;
    print_verdict;
  end
endmodule
